// ### common/adc_ctrl_pkg.sv
package adc_ctrl_pkg;

    // converter clock divider and conversion length
    localparam int CLK_DIV = 4;
    localparam int CONV_PERIODS = 12;
    localparam int CONV_CYCLES = CLK_DIV * CONV_PERIODS;
    localparam int CHAN_W = 4;
    localparam int RES_W = 8;
    localparam int CNT_W = 6;
    // stabilization after halt wake-up, in converter periods
    localparam int STAB_PERIODS = 12;
    localparam int STAB_CYCLES = CLK_DIV * STAB_PERIODS;
    localparam logic [CHAN_W-1:0] CHAN_RESET = 4'h0;
    localparam logic [RES_W-1:0] RESULT_RESET = 8'h00;
    localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;

    // control/status word as written by software
    typedef struct packed {
        logic converterOn;
        logic [CHAN_W-1:0] channelSelect;
    } ctrl_s;

    typedef enum logic [1:0] {
        ST_OFF = 2'b00,
        ST_CONV = 2'b01,
        ST_STAB = 2'b11
    } conv_state_e;

endpackage : adc_ctrl_pkg

// ### design/adc_conversion_control.sv
// Operation
// - each conversion lasts twelve converter clocks; converter clock is CPU clock over four
// - four-bit channel select routes one analog input to the converter
// - setting converter-on powers up and starts first conversion at once
// - while converter-on stays set, conversions run back to back
// - hardware sets completion flag at end of every conversion
// - no interrupt on completion; software polls the flag
// - result register holds last result until next conversion ends
// - control write with converter-on set during a conversion aborts, clears flag, restarts
// - wait mode changes nothing about conversions, flag or result
// - halt disables converter; after wake-up a stabilization interval follows
// - clearing converter-on stops conversions and powers converter down
// - result is eight bits; up to sixteen multiplexed channels
`timescale 1ns/1ps
module adc_conversion_control #(
    parameter int CONV_CYCLES = adc_ctrl_pkg::CONV_CYCLES,
    parameter int STAB_CYCLES = adc_ctrl_pkg::STAB_CYCLES
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic ctrlWrite,
    input wire adc_ctrl_pkg::ctrl_s ctrlData,
    input wire logic waitMode,
    input wire logic haltMode,
    input wire logic [adc_ctrl_pkg::RES_W-1:0] sarResult,
    output logic converterOn,
    output logic [adc_ctrl_pkg::CHAN_W-1:0] channelSelect,
    output logic conversionCompleteFlag,
    output logic [adc_ctrl_pkg::RES_W-1:0] conversionResult,
    output logic analogPowerOn,
    output logic sampleStart,
    output logic converterClock,
    output logic stabilizing
);

    adc_ctrl_pkg::ctrl_s ctrl_reg, ctrl_next;
    adc_ctrl_pkg::conv_state_e state_reg, state_next;
    logic [adc_ctrl_pkg::CNT_W-1:0] cnt_reg, cnt_next;
    logic [1:0] div_reg, div_next;
    logic flag_reg, flag_next;
    logic [adc_ctrl_pkg::RES_W-1:0] result_reg, result_next;
    logic start_reg, start_next;
    logic haltSeen_reg, haltSeen_next;
    logic convDone;

    localparam logic [adc_ctrl_pkg::CNT_W-1:0] CONV_LAST = 6'(CONV_CYCLES - 1);
    localparam logic [adc_ctrl_pkg::CNT_W-1:0] STAB_LAST = 6'(STAB_CYCLES - 1);

    // conversion ends on the last CPU cycle of the twelfth converter period
    assign convDone = (state_reg == adc_ctrl_pkg::ST_CONV) && (cnt_reg == CONV_LAST) && !haltMode;

    // sequencing of power, conversions, flag and result; waitMode is deliberately unused
    always_comb
    begin
        ctrl_next = ctrl_reg;
        state_next = state_reg;
        cnt_next = cnt_reg;
        div_next = div_reg + 2'h1;
        flag_next = flag_reg;
        result_next = result_reg;
        start_next = 1'b0;
        haltSeen_next = haltSeen_reg;
        if (ctrlWrite)
        begin
            ctrl_next = ctrlData;
        end
        if (convDone)
        begin
            flag_next = 1'b1;
            result_next = sarResult;
        end
        case (state_reg)
            adc_ctrl_pkg::ST_OFF:
            begin
                if (ctrlWrite && ctrlData.converterOn && !haltMode)
                begin
                    state_next = haltSeen_reg ? adc_ctrl_pkg::ST_STAB : adc_ctrl_pkg::ST_CONV;
                    cnt_next = adc_ctrl_pkg::CNT_ZERO;
                    div_next = 2'h0;
                    start_next = !haltSeen_reg;
                    flag_next = 1'b0;
                end
            end
            adc_ctrl_pkg::ST_CONV, adc_ctrl_pkg::ST_STAB:
            begin
                cnt_next = cnt_reg + 6'h01;
                if (state_reg == adc_ctrl_pkg::ST_STAB && cnt_reg == STAB_LAST)
                begin
                    state_next = adc_ctrl_pkg::ST_CONV;
                    cnt_next = adc_ctrl_pkg::CNT_ZERO;
                    div_next = 2'h0;
                    start_next = 1'b1;
                    haltSeen_next = 1'b0;
                end
                if (convDone)
                begin
                    cnt_next = adc_ctrl_pkg::CNT_ZERO;
                    start_next = 1'b1;
                end
                if (ctrlWrite && ctrlData.converterOn && state_reg == adc_ctrl_pkg::ST_CONV)
                begin
                    cnt_next = adc_ctrl_pkg::CNT_ZERO;
                    div_next = 2'h0;
                    start_next = 1'b1;
                    flag_next = 1'b0;
                    result_next = result_reg;
                end
                if (ctrlWrite && !ctrlData.converterOn)
                begin
                    state_next = adc_ctrl_pkg::ST_OFF;
                    start_next = 1'b0;
                end
            end
            default:
            begin
                state_next = adc_ctrl_pkg::ST_OFF;
            end
        endcase
        if (haltMode)
        begin
            state_next = adc_ctrl_pkg::ST_OFF;
            start_next = 1'b0;
            haltSeen_next = 1'b1;
        end
        else if (haltSeen_reg && state_reg == adc_ctrl_pkg::ST_OFF && ctrl_reg.converterOn && !ctrlWrite)
        begin
            state_next = adc_ctrl_pkg::ST_STAB;
            cnt_next = adc_ctrl_pkg::CNT_ZERO;
        end
    end

    // state registers
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            ctrl_reg <= '{converterOn: 1'b0, channelSelect: adc_ctrl_pkg::CHAN_RESET};
            state_reg <= adc_ctrl_pkg::ST_OFF;
            cnt_reg <= adc_ctrl_pkg::CNT_ZERO;
            div_reg <= 2'h0;
            flag_reg <= 1'b0;
            result_reg <= adc_ctrl_pkg::RESULT_RESET;
            start_reg <= 1'b0;
            haltSeen_reg <= 1'b0;
        end
        else
        begin
            ctrl_reg <= ctrl_next;
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            div_reg <= div_next;
            flag_reg <= flag_next;
            result_reg <= result_next;
            start_reg <= start_next;
            haltSeen_reg <= haltSeen_next;
        end
    end

    // outputs
    assign converterOn = ctrl_reg.converterOn;
    assign channelSelect = ctrl_reg.channelSelect;
    assign conversionCompleteFlag = flag_reg;
    assign conversionResult = result_reg;
    assign analogPowerOn = (state_reg != adc_ctrl_pkg::ST_OFF);
    assign sampleStart = start_reg;
    assign converterClock = div_reg[1];
    assign stabilizing = (state_reg == adc_ctrl_pkg::ST_STAB);

    // checks
    AST_RESET_CLEAR: assert property (@(posedge clock) rst |=> !converterOn && !conversionCompleteFlag
        && channelSelect == 4'h0 && !analogPowerOn) else $error("reset state wrong");
    AST_START_ON: assert property (@(posedge clock) disable iff (rst)
        (ctrlWrite && ctrlData.converterOn && !haltMode && !haltSeen_reg) |=> sampleStart && analogPowerOn)
        else $error("no start after enable");
    AST_LENGTH: assert property (@(posedge clock) disable iff (rst)
        (sampleStart && !ctrlWrite && !haltMode) ##1 (!ctrlWrite && !haltMode)[*8]
        |-> !$rose(conversionCompleteFlag)) else $error("conversion too short");
    AST_FLAG_SET: assert property (@(posedge clock) disable iff (rst)
        convDone && !ctrlWrite |=> conversionCompleteFlag) else $error("flag not set");
    AST_RESULT_LOAD: assert property (@(posedge clock) disable iff (rst)
        convDone && !ctrlWrite |=> conversionResult == $past(sarResult)) else $error("result not loaded");
    AST_RESULT_HOLD: assert property (@(posedge clock) disable iff (rst)
        !convDone |=> $stable(conversionResult)) else $error("result changed");
    AST_ABORT: assert property (@(posedge clock) disable iff (rst)
        ctrlWrite && ctrlData.converterOn && state_reg == adc_ctrl_pkg::ST_CONV && !haltMode
        |=> !conversionCompleteFlag && sampleStart) else $error("abort failed");
    AST_BACK_TO_BACK: assert property (@(posedge clock) disable iff (rst)
        convDone && !ctrlWrite |=> sampleStart) else $error("no restart");
    AST_OFF: assert property (@(posedge clock) disable iff (rst)
        ctrlWrite && !ctrlData.converterOn |=> !analogPowerOn ##1 !sampleStart) else $error("not off");
    AST_HALT: assert property (@(posedge clock) disable iff (rst)
        haltMode |=> !analogPowerOn && !sampleStart) else $error("halt not off");
    AST_WAIT: assert property (@(posedge clock) disable iff (rst)
        convDone && waitMode && !ctrlWrite |=> conversionCompleteFlag) else $error("wait changed");
    // flag is sticky: only a control write may take it down
    AST_FLAG_STICKY: assert property (@(posedge clock) disable iff (rst)
        conversionCompleteFlag && !ctrlWrite |=> conversionCompleteFlag) else $error("flag dropped");
    // channel field only moves on a control write
    AST_CHAN_HOLD: assert property (@(posedge clock) disable iff (rst)
        !ctrlWrite |=> $stable(channelSelect)) else $error("channel changed");
    AST_NO_START_OFF: assert property (@(posedge clock) disable iff (rst)
        !analogPowerOn |-> !sampleStart) else $error("start while off");
    AST_STAB_LEN: assert property (@(posedge clock) disable iff (rst)
        $rose(stabilizing) |-> stabilizing[*8]) else $error("stabilization too short");
    AST_CNT_RANGE: assert property (@(posedge clock) disable iff (rst)
        state_reg == adc_ctrl_pkg::ST_CONV |-> cnt_reg <= CONV_LAST) else $error("count overran");
    // main scenarios
    COV_CONV: cover property (@(posedge clock) convDone);
    COV_ABORT: cover property (@(posedge clock) ctrlWrite && ctrlData.converterOn && state_reg == adc_ctrl_pkg::ST_CONV);
    COV_STAB: cover property (@(posedge clock) $fell(stabilizing));
    COV_BACK: cover property (@(posedge clock) convDone ##1 sampleStart);
    COV_HALT: cover property (@(posedge clock) haltMode && analogPowerOn);

endmodule : adc_conversion_control

// ### tb/adc_conversion_control_tb_top.sv
`timescale 1ns/1ps
module adc_conversion_control_tb_top;
    localparam int STAB = 8;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic ctrlWrite = 1'b0;
    adc_ctrl_pkg::ctrl_s ctrlData = '0;
    logic waitMode = 1'b0;
    logic haltMode = 1'b0;
    logic [7:0] sarResult, conversionResult;
    logic [3:0] channelSelect;
    logic converterOn, conversionCompleteFlag, analogPowerOn, sampleStart, converterClock, stabilizing, cc;
    int miscompares = 0;
    int checks = 0;
    int cycles = 0;
    int n;
    adc_conversion_control #(.STAB_CYCLES(STAB)) dut_u (.clock(clock), .rst(rst), .ctrlWrite(ctrlWrite),
        .ctrlData(ctrlData), .waitMode(waitMode), .haltMode(haltMode), .sarResult(sarResult),
        .converterOn(converterOn), .channelSelect(channelSelect), .conversionCompleteFlag(conversionCompleteFlag),
        .conversionResult(conversionResult), .analogPowerOn(analogPowerOn), .sampleStart(sampleStart),
        .converterClock(converterClock), .stabilizing(stabilizing));
    sar_core_model core_u (.clock(clock), .analogPowerOn(analogPowerOn), .sampleStart(sampleStart),
        .channelSelect(channelSelect), .sarResult(sarResult));
    // clock and hang guard
    always #5 clock = ~clock;
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            miscompares++;
            wrap_up();
        end
    end
    task check(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin miscompares++; $display("mismatch at %0t: got %h expected %h", $time, got, exp); end
    endtask : check
    task cyc(input int k);
        repeat (k) @(posedge clock);
        #1;
    endtask : cyc
    // control word write; returns just after the edge that takes it
    task wr(input logic on, input logic [3:0] ch);
        @(posedge clock);
        ctrlWrite <= 1'b1;
        ctrlData <= '{converterOn: on, channelSelect: ch};
        @(posedge clock);
        ctrlWrite <= 1'b0;
        #1;
    endtask : wr
    // one whole conversion from its start pulse to the next start
    task conv(input logic [3:0] ch);
        check(sampleStart, 1'b1);
        check(converterClock, 1'b0);
        cyc(2);
        check(converterClock, 1'b1);
        cyc(45);
        check(conversionCompleteFlag, 1'b0);
        cyc(1);
        check(conversionCompleteFlag, 1'b1);
        check(conversionResult, {~ch, ch});
        check(sampleStart, 1'b1);
    endtask : conv
    task wrap_up;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up
    // main sequence; no interrupt port exists, completion is polled only
    initial
    begin
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        cyc(1);
        check({converterOn, conversionCompleteFlag, analogPowerOn, sampleStart, channelSelect}, 8'h00);
        wr(1'b1, 4'h3);
        check({converterOn, analogPowerOn, channelSelect}, 8'h33);
        conv(4'h3);
        cyc(10);
        waitMode <= 1'b1;
        wr(1'b1, 4'hc);
        check(conversionCompleteFlag, 1'b0);
        check(conversionResult, 8'hc3);
        conv(4'hc);
        wr(1'b0, 4'hc);
        check({analogPowerOn, conversionCompleteFlag}, 8'h01);
        n = 0;
        repeat (60) begin cyc(1); n += sampleStart; end
        check(n[7:0], 8'h00);
        wr(1'b1, 4'hf);
        @(posedge clock);
        haltMode <= 1'b1;
        cyc(1);
        check(analogPowerOn, 1'b0);
        cyc(60);
        check(conversionCompleteFlag, 1'b0);
        haltMode <= 1'b0;
        cyc(1);
        check(stabilizing, 1'b1);
        n = 0;
        while (sampleStart !== 1'b1 && n < 40) begin cyc(1); n++; end
        check(n >= STAB - 2 && n <= STAB + 1, 1'b1);
        conv(4'hf);
        wr(1'b0, 4'hf);
        @(posedge clock);
        haltMode <= 1'b1;
        repeat (3) @(posedge clock);
        haltMode <= 1'b0;
        cyc(3);
        check({analogPowerOn, stabilizing, sampleStart}, 8'h00);
        wrap_up();
    end
endmodule : adc_conversion_control_tb_top

// ### tb/sar_core_model.sv
`timescale 1ns/1ps
// stand-in for the analog core and input mux; each channel reads a fixed code
module sar_core_model (
    input wire logic clock,
    input wire logic analogPowerOn,
    input wire logic sampleStart,
    input wire logic [3:0] channelSelect,
    output logic [7:0] sarResult
);
    logic [7:0] held_reg = 8'h00;
    // sample and hold of the routed input at each start
    always @(posedge clock)
        if (sampleStart) held_reg <= {~channelSelect, channelSelect};
    // a powered-down core gives no valid code, so show the inverse
    assign sarResult = analogPowerOn ? held_reg : ~held_reg;
endmodule : sar_core_model
